// [ise_pkg.sv]
package ise_pkg;

  // --------------------
  // operand sizes and operand sources
  // --------------------
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_IMM = 2'h1;
  localparam logic [1:0] SRC_MEM = 2'h2;

  // --------------------
  // status word layout and reset value
  // --------------------
  localparam int SR_S_BIT = 13;
  localparam int SR_X_BIT = 4;
  localparam logic [15:0] SR_RST = 16'h2700;
  localparam logic [3:0] SP_IDX = 4'hF;

  // --------------------
  // memory function codes and control register selects
  // --------------------
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [1:0] CTL_SFC = 2'h0;
  localparam logic [1:0] CTL_DFC = 2'h1;
  localparam logic [1:0] CTL_USP = 2'h2;
  localparam logic [1:0] CTL_VBR = 2'h3;

  // --------------------
  // shifter kinds and timing
  // --------------------
  localparam logic [1:0] SHK_LOG = 2'h0;
  localparam logic [1:0] SHK_ROT = 2'h1;
  localparam logic [1:0] SHK_ROX = 2'h2;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam int CLK_NS = 100;
  localparam int RST_LINE_NS = 1600;
  localparam int RST_LINE_CYC = (RST_LINE_NS + CLK_NS - 1) / CLK_NS;

  // --------------------
  // operations and sequencer states
  // --------------------
  typedef enum logic [4:0] {
    OP_LEA = 5'h00, OP_LINK = 5'h01, OP_LSH = 5'h02, OP_MVFSR = 5'h03,
    OP_MVTSR = 5'h04, OP_MVUSP = 5'h05, OP_MVC = 5'h06, OP_MVS = 5'h07,
    OP_MVM = 5'h08, OP_SIGNED_MULTIPLY = 5'h09, OP_UNSIGNED_MULTIPLY = 5'h0A, OP_DECIMAL_NEGATE = 5'h0B,
    OP_NEG = 5'h0C, OP_COMPLEMENT_WITH_EXTEND = 5'h0D, OP_OR = 5'h0E, OP_ORI = 5'h0F,
    OP_ORISR = 5'h10, OP_PEA = 5'h11, OP_RST = 5'h12, OP_ROT = 5'h13,
    OP_ROX = 5'h14, OP_RTD = 5'h15
  } ise_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RD = 3'h1, ST_EXEC = 3'h2, ST_WR = 3'h3,
    ST_MM = 3'h4
  } ise_state_t;

endpackage

// [ise_exec.sv]
// Function
// - lea writes the address itself
// - frame setup pushes register, copies, adjusts stack
// - logical shift by register, immediate or one
// - status read traps in user state, later variant
// - status write only in supervisor, else trap
// - user stack pointer alternate_space_move only in supervisor
// - control register move only in supervisor
// - multi register move stores or loads list
// - signed 16x16 multiply gives 32-bit product
// - unsigned 16x16 multiply gives 32-bit product
// - decimal negate subtracts operand and borrow
// - twos complement negates destination
// - negate with extend subtracts borrow too
// - or of source and destination, both directions
// - or immediate into destination
// - or immediate into status only supervisor
// - push address decrements stack by four
// - reset line only in supervisor, else trap
// - rotate with bits wrapping end to end
// - rotate through extend flag as extra bit
// - return pops pc, adds four plus displacement
// - both directions for every shift and rotate
`timescale 1ns/1ns
`default_nettype none

module ise_exec #(
  parameter bit P_LATER = 1'b1,
  parameter int P_RST_CYC = ise_pkg::RST_LINE_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // instruction command from the decoder
  input wire logic i_cmd_valid,
  input wire logic [4:0] i_op,
  input wire logic [1:0] i_size,
  input wire logic i_dir,
  input wire logic [3:0] i_rx,
  input wire logic [3:0] i_ry,
  input wire logic [1:0] i_src_sel,
  input wire logic i_dst_mem,
  input wire logic [31:0] i_imm,
  input wire logic [31:0] i_ea,
  input wire logic [15:0] i_list,
  input wire logic [1:0] i_ctl_sel,
  // command status
  output logic o_busy_q,
  output logic o_done_q,
  output logic o_trap_q,
  // memory port
  output logic o_mem_req_q,
  output logic o_mem_we_q,
  output logic [31:0] o_mem_addr_q,
  output logic [31:0] o_mem_wdata_q,
  output logic [1:0] o_mem_size_q,
  output logic [2:0] o_mem_fc_q,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // architectural state and pins
  output logic [31:0] o_pc_q,
  output logic [15:0] o_sr_q,
  output logic o_reset_line_q,
  // register peek
  input wire logic [3:0] i_dbg_sel,
  output logic [31:0] o_dbg_data_q
);

  // --------------------
  // helpers
  // --------------------
  // one step per count; returns {extend out, result}
  function automatic logic [32:0] f_shift(input logic [1:0] kind,
      input logic left, input logic [31:0] v, input logic [5:0] cnt,
      input logic [1:0] sz, input logic x);
    logic [31:0] r;
    logic xo;
    logic b;
    logic [4:0] msb;
    r = v;
    xo = x;
    msb = (sz == ise_pkg::SZ_B) ? 5'h07 :
          (sz == ise_pkg::SZ_W) ? 5'h0F : 5'h1F;
    for (int i = 0; i < 64; i++) begin
      if (6'(i) < cnt) begin
        if (left) begin
          b = r[msb];
          r = r << 1;
          r[0] = (kind == ise_pkg::SHK_ROT) ? b :
                 (kind == ise_pkg::SHK_ROX) ? xo : 1'b0;
        end else begin
          b = r[0];
          r = r >> 1;
          r[msb] = (kind == ise_pkg::SHK_ROT) ? b :
                   (kind == ise_pkg::SHK_ROX) ? xo : 1'b0;
        end
        xo = b;
      end
    end
    return {xo, r};
  endfunction

  // keep untouched upper bits of a register
  function automatic logic [31:0] f_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [1:0] sz);
    case (sz)
      ise_pkg::SZ_B: return {old[31:8], nw[7:0]};
      ise_pkg::SZ_W: return {old[31:16], nw[15:0]};
      default: return nw;
    endcase
  endfunction

  // --------------------
  // state
  // --------------------
  ise_pkg::ise_state_t st_q, st_d;
  ise_pkg::ise_op_t op_q, op_d;
  logic [31:0] rf_q [16];
  logic [31:0] rf_d [16];
  logic [31:0] sp_alt_q, sp_alt_d, vbr_q, vbr_d;
  logic [2:0] sfc_q, sfc_d, dfc_q, dfc_d;
  logic [1:0] size_q, size_d, src_sel_q, src_sel_d, ctl_q, ctl_d;
  logic dir_q, dir_d, dst_mem_q, dst_mem_d;
  logic [3:0] rx_q, rx_d, mm_idx_q, mm_idx_d;
  logic [31:0] src_q, src_d, dst_q, dst_d, imm_q, imm_d;
  logic [15:0] list_q, list_d, sr_d;
  logic [31:0] pc_d, addr_d, wdata_d;
  logic req_d, we_d, done_d, trap_d, busy_d;
  logic [1:0] msize_d;
  logic [2:0] fc_d;
  logic [15:0] rst_cnt_q, rst_cnt_d;
  logic [31:0] res, sp_dec;
  logic [32:0] sh;
  logic [5:0] cnt;
  logic [1:0] kind;
  logic [4:0] dlo, dhi;
  logic sup, priv, bor;

  // --------------------
  // next-state logic
  // --------------------
  always_comb begin
    st_d = st_q; op_d = op_q; rf_d = rf_q; sp_alt_d = sp_alt_q;
    vbr_d = vbr_q; sfc_d = sfc_q; dfc_d = dfc_q; size_d = size_q;
    src_sel_d = src_sel_q; ctl_d = ctl_q; dir_d = dir_q;
    dst_mem_d = dst_mem_q; rx_d = rx_q; mm_idx_d = mm_idx_q;
    src_d = src_q; dst_d = dst_q; imm_d = imm_q; list_d = list_q;
    sr_d = o_sr_q; pc_d = o_pc_q; addr_d = o_mem_addr_q;
    wdata_d = o_mem_wdata_q; req_d = o_mem_req_q; we_d = o_mem_we_q;
    msize_d = o_mem_size_q; fc_d = o_mem_fc_q;
    done_d = 1'b0; trap_d = 1'b0;
    sup = o_sr_q[ise_pkg::SR_S_BIT];
    rst_cnt_d = (rst_cnt_q != 16'h0000) ? rst_cnt_q - 16'h0001 : rst_cnt_q;
    sp_dec = rf_q[ise_pkg::SP_IDX] - ise_pkg::STACK_STEP;
    // count: register modulo 64, immediate 1..8, memory form one
    cnt = (src_sel_q == ise_pkg::SRC_REG) ? src_q[5:0] :
          (src_sel_q == ise_pkg::SRC_IMM) ?
          ((imm_q[2:0] == 3'h0) ? 6'h08 : {3'h0, imm_q[2:0]}) : 6'h01;
    kind = (op_q == ise_pkg::OP_ROT) ? ise_pkg::SHK_ROT :
           (op_q == ise_pkg::OP_ROX) ? ise_pkg::SHK_ROX : ise_pkg::SHK_LOG;
    sh = f_shift(kind, dir_q, dst_q, cnt, size_q,
                 o_sr_q[ise_pkg::SR_X_BIT]);
    // decimal digits of zero minus operand minus extend
    bor = o_sr_q[ise_pkg::SR_X_BIT];
    dlo = {1'b0, dst_q[3:0]} + {4'h0, bor};
    dhi = {1'b0, dst_q[7:4]} + {4'h0, dlo != 5'h00};
    res = 32'h0000_0000;
    priv = 1'b0;
    unique case (st_q)
      ise_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          op_d = ise_pkg::ise_op_t'(i_op);
          size_d = i_size; dir_d = i_dir; rx_d = i_rx;
          src_sel_d = i_src_sel; dst_mem_d = i_dst_mem; imm_d = i_imm;
          ctl_d = i_ctl_sel; list_d = i_list; addr_d = i_ea;
          src_d = (i_src_sel == ise_pkg::SRC_IMM) ? i_imm : rf_q[i_ry];
          dst_d = rf_q[i_rx];
          fc_d = sup ? ise_pkg::FC_SUP_DATA : ise_pkg::FC_USER_DATA;
          msize_d = i_size;
          case (i_op)
            ise_pkg::OP_MVTSR, ise_pkg::OP_ORISR, ise_pkg::OP_MVUSP,
            ise_pkg::OP_MVC, ise_pkg::OP_MVS,
            ise_pkg::OP_RST: priv = 1'b1;
            ise_pkg::OP_MVFSR: priv = P_LATER;
            default: priv = 1'b0;
          endcase
          if (priv && !sup) begin
            trap_d = 1'b1;
            done_d = 1'b1;
          end else if (i_op == ise_pkg::OP_MVM) begin
            st_d = ise_pkg::ST_MM;
          end else if (i_op == ise_pkg::OP_RTD) begin
            addr_d = rf_q[ise_pkg::SP_IDX];
            msize_d = ise_pkg::SZ_L;
            src_sel_d = ise_pkg::SRC_MEM;
            req_d = 1'b1; we_d = 1'b0; st_d = ise_pkg::ST_RD;
          end else if (i_op == ise_pkg::OP_MVS) begin
            fc_d = i_dir ? dfc_q : sfc_q;
            req_d = !i_dir; we_d = 1'b0;
            src_sel_d = ise_pkg::SRC_MEM;
            dst_mem_d = i_dir;
            src_d = rf_q[i_rx];
            st_d = i_dir ? ise_pkg::ST_EXEC : ise_pkg::ST_RD;
          end else if ((i_src_sel == ise_pkg::SRC_MEM || i_dst_mem) &&
                       i_op != ise_pkg::OP_LEA &&
                       i_op != ise_pkg::OP_PEA &&
                       i_op != ise_pkg::OP_MVFSR) begin
            req_d = 1'b1; we_d = 1'b0; st_d = ise_pkg::ST_RD;
          end else begin
            st_d = ise_pkg::ST_EXEC;
          end
        end
      end
      ise_pkg::ST_RD: begin
        if (i_mem_ack) begin
          req_d = 1'b0;
          if (src_sel_q == ise_pkg::SRC_MEM) src_d = i_mem_rdata;
          else dst_d = i_mem_rdata;
          st_d = ise_pkg::ST_EXEC;
        end
      end
      ise_pkg::ST_EXEC: begin
        st_d = ise_pkg::ST_IDLE;
        done_d = 1'b1;
        case (op_q)
          ise_pkg::OP_LEA: rf_d[rx_q] = o_mem_addr_q;
          ise_pkg::OP_LINK, ise_pkg::OP_PEA: begin
            rf_d[ise_pkg::SP_IDX] = sp_dec;
            addr_d = sp_dec;
            wdata_d = (op_q == ise_pkg::OP_PEA) ? o_mem_addr_q : dst_q;
            msize_d = ise_pkg::SZ_L; req_d = 1'b1; we_d = 1'b1;
            done_d = 1'b0; st_d = ise_pkg::ST_WR;
          end
          ise_pkg::OP_MVFSR: res = {16'h0000, o_sr_q};
          ise_pkg::OP_MVTSR: sr_d = src_q[15:0];
          ise_pkg::OP_ORISR: sr_d = o_sr_q | imm_q[15:0];
          ise_pkg::OP_MVUSP: begin
            if (dir_q) sp_alt_d = dst_q;
            else rf_d[rx_q] = sp_alt_q;
          end
          ise_pkg::OP_MVC: begin
            if (dir_q) begin
              unique case (ctl_q)
                ise_pkg::CTL_SFC: sfc_d = dst_q[2:0];
                ise_pkg::CTL_DFC: dfc_d = dst_q[2:0];
                ise_pkg::CTL_USP: sp_alt_d = dst_q;
                ise_pkg::CTL_VBR: vbr_d = dst_q;
              endcase
            end else begin
              unique case (ctl_q)
                ise_pkg::CTL_SFC: rf_d[rx_q] = {29'h0, sfc_q};
                ise_pkg::CTL_DFC: rf_d[rx_q] = {29'h0, dfc_q};
                ise_pkg::CTL_USP: rf_d[rx_q] = sp_alt_q;
                ise_pkg::CTL_VBR: rf_d[rx_q] = vbr_q;
              endcase
            end
          end
          ise_pkg::OP_MVS: res = src_q;
          ise_pkg::OP_SIGNED_MULTIPLY:
            res = $signed(src_q[15:0]) * $signed(dst_q[15:0]);
          ise_pkg::OP_UNSIGNED_MULTIPLY: res = src_q[15:0] * dst_q[15:0];
          ise_pkg::OP_DECIMAL_NEGATE: begin
            res[3:0] = (dlo == 5'h00) ? 4'h0 : 4'(5'h0A - dlo);
            res[7:4] = (dhi == 5'h00) ? 4'h0 : 4'(5'h0A - dhi);
            sr_d[ise_pkg::SR_X_BIT] = (dhi != 5'h00);
          end
          ise_pkg::OP_NEG: begin
            res = 32'h0000_0000 - dst_q;
            sr_d[ise_pkg::SR_X_BIT] = (f_merge(32'h0, dst_q, size_q) != 0);
          end
          ise_pkg::OP_COMPLEMENT_WITH_EXTEND: begin
            res = 32'h0000_0000 - dst_q - {31'h0, bor};
            sr_d[ise_pkg::SR_X_BIT] =
              (f_merge(32'h0, dst_q, size_q) != 0) || bor;
          end
          ise_pkg::OP_OR, ise_pkg::OP_ORI: res = src_q | dst_q;
          ise_pkg::OP_LSH, ise_pkg::OP_ROT, ise_pkg::OP_ROX: begin
            res = sh[31:0];
            if (op_q != ise_pkg::OP_ROT && cnt != 6'h00)
              sr_d[ise_pkg::SR_X_BIT] = sh[32];
          end
          ise_pkg::OP_RST: rst_cnt_d = 16'(P_RST_CYC);
          ise_pkg::OP_RTD: begin
            pc_d = src_q;
            rf_d[ise_pkg::SP_IDX] = rf_q[ise_pkg::SP_IDX] +
                                    ise_pkg::STACK_STEP + imm_q;
          end
          default: ;
        endcase
        // result write-back for operand-producing operations
        case (op_q)
          ise_pkg::OP_MVFSR, ise_pkg::OP_MVS, ise_pkg::OP_SIGNED_MULTIPLY,
          ise_pkg::OP_UNSIGNED_MULTIPLY, ise_pkg::OP_DECIMAL_NEGATE, ise_pkg::OP_NEG,
          ise_pkg::OP_COMPLEMENT_WITH_EXTEND, ise_pkg::OP_OR, ise_pkg::OP_ORI,
          ise_pkg::OP_LSH, ise_pkg::OP_ROT, ise_pkg::OP_ROX: begin
            if (dst_mem_q) begin
              wdata_d = res; req_d = 1'b1; we_d = 1'b1;
              done_d = 1'b0; st_d = ise_pkg::ST_WR;
            end else if (op_q == ise_pkg::OP_SIGNED_MULTIPLY ||
                         op_q == ise_pkg::OP_UNSIGNED_MULTIPLY) begin
              rf_d[rx_q] = res;
            end else if (op_q == ise_pkg::OP_MVFSR) begin
              rf_d[rx_q] = f_merge(dst_q, res, ise_pkg::SZ_W);
            end else begin
              rf_d[rx_q] = f_merge(dst_q, res, size_q);
            end
          end
          default: ;
        endcase
      end
      ise_pkg::ST_WR: begin
        if (i_mem_ack) begin
          req_d = 1'b0; we_d = 1'b0;
          st_d = ise_pkg::ST_IDLE; done_d = 1'b1;
          if (op_q == ise_pkg::OP_LINK) begin
            rf_d[rx_q] = rf_q[ise_pkg::SP_IDX];
            rf_d[ise_pkg::SP_IDX] = rf_q[ise_pkg::SP_IDX] + imm_q;
          end
        end
      end
      ise_pkg::ST_MM: begin
        // lowest listed register first, ascending addresses
        if (!o_mem_req_q) begin
          if (list_q == 16'h0000) begin
            st_d = ise_pkg::ST_IDLE; done_d = 1'b1;
          end else begin
            for (int i = 15; i >= 0; i--)
              if (list_q[i]) mm_idx_d = 4'(i);
            req_d = 1'b1; we_d = dir_q;
            wdata_d = rf_q[mm_idx_d];
          end
        end else if (i_mem_ack) begin
          req_d = 1'b0;
          list_d[mm_idx_q] = 1'b0;
          addr_d = o_mem_addr_q + (32'h0000_0001 << size_q); // 1, 2 or 4
          if (!we_d)
            rf_d[mm_idx_q] = (size_q == ise_pkg::SZ_W) ?
              {{16{i_mem_rdata[15]}}, i_mem_rdata[15:0]} : i_mem_rdata;
        end
      end
      default: st_d = ise_pkg::ST_IDLE;
    endcase
    // leaving or entering supervisor swaps the active stack pointer
    if (sr_d[ise_pkg::SR_S_BIT] != o_sr_q[ise_pkg::SR_S_BIT]) begin
      rf_d[ise_pkg::SP_IDX] = sp_alt_q;
      sp_alt_d = rf_q[ise_pkg::SP_IDX];
    end
    busy_d = (st_d != ise_pkg::ST_IDLE);
  end

  // --------------------
  // registers
  // --------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ise_pkg::ST_IDLE; op_q <= ise_pkg::OP_LEA;
      for (int i = 0; i < 16; i++) rf_q[i] <= 32'h0000_0000;
      sp_alt_q <= 32'h0000_0000; vbr_q <= 32'h0000_0000;
      sfc_q <= 3'h0; dfc_q <= 3'h0; size_q <= 2'h0; src_sel_q <= 2'h0;
      ctl_q <= 2'h0; dir_q <= 1'b0; dst_mem_q <= 1'b0; rx_q <= 4'h0;
      mm_idx_q <= 4'h0; src_q <= 32'h0000_0000; dst_q <= 32'h0000_0000;
      imm_q <= 32'h0000_0000; list_q <= 16'h0000; rst_cnt_q <= 16'h0000;
      o_sr_q <= ise_pkg::SR_RST; o_pc_q <= 32'h0000_0000;
      o_mem_addr_q <= 32'h0000_0000; o_mem_wdata_q <= 32'h0000_0000;
      o_mem_req_q <= 1'b0; o_mem_we_q <= 1'b0; o_mem_size_q <= 2'h0;
      o_mem_fc_q <= 3'h0; o_done_q <= 1'b0; o_trap_q <= 1'b0;
      o_busy_q <= 1'b0; o_reset_line_q <= 1'b0;
      o_dbg_data_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d; op_q <= op_d; rf_q <= rf_d;
      sp_alt_q <= sp_alt_d; vbr_q <= vbr_d; sfc_q <= sfc_d; dfc_q <= dfc_d;
      size_q <= size_d; src_sel_q <= src_sel_d; ctl_q <= ctl_d;
      dir_q <= dir_d; dst_mem_q <= dst_mem_d; rx_q <= rx_d;
      mm_idx_q <= mm_idx_d; src_q <= src_d; dst_q <= dst_d;
      imm_q <= imm_d; list_q <= list_d; rst_cnt_q <= rst_cnt_d;
      o_sr_q <= sr_d; o_pc_q <= pc_d; o_mem_addr_q <= addr_d;
      o_mem_wdata_q <= wdata_d; o_mem_req_q <= req_d; o_mem_we_q <= we_d;
      o_mem_size_q <= msize_d; o_mem_fc_q <= fc_d; o_done_q <= done_d;
      o_trap_q <= trap_d; o_busy_q <= busy_d;
      o_reset_line_q <= (rst_cnt_d != 16'h0000);
      o_dbg_data_q <= rf_q[i_dbg_sel];
    end
  end

endmodule

`default_nettype wire

// [ise_exec_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module ise_exec_chk #(
  parameter bit P_LATER = 1'b1,
  parameter int P_RST_CYC = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // command side
  input wire logic i_cmd_valid,
  input wire logic [4:0] i_op,
  input wire logic o_busy_q,
  input wire logic o_done_q,
  input wire logic o_trap_q,
  // memory side
  input wire logic o_mem_req_q,
  input wire logic o_mem_we_q,
  input wire logic [31:0] o_mem_addr_q,
  input wire logic [31:0] o_mem_wdata_q,
  input wire logic [1:0] o_mem_size_q,
  input wire logic [2:0] o_mem_fc_q,
  input wire logic i_mem_ack,
  // state and pins
  input wire logic [15:0] o_sr_q,
  input wire logic o_reset_line_q
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic sup, priv, rst_op;
  logic [7:0] hi_q, hi_d;
  // privilege state and privileged operations
  assign sup = o_sr_q[ise_pkg::SR_S_BIT];
  assign rst_op = i_op == ise_pkg::OP_RST;
  assign priv = rst_op || (i_op inside {ise_pkg::OP_MVTSR, ise_pkg::OP_MVUSP,
    ise_pkg::OP_MVC, ise_pkg::OP_MVS, ise_pkg::OP_ORISR}) ||
    (P_LATER && i_op == ise_pkg::OP_MVFSR);
  // length of the running reset-line pulse
  always_comb begin
    hi_d = o_reset_line_q ? hi_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
    end
  end
  sequence take_s;
    i_cmd_valid && !o_busy_q;
  endsequence
  sequence trap_s;
    o_trap_q && o_done_q && $stable(o_sr_q);
  endsequence
  priv_trap_a:
    assert property (take_s ##0 (priv && !sup) |=> trap_s)
    else $error("user op not trapped");
  no_trap_a:
    assert property (take_s ##0 (sup || !priv) |=> !o_trap_q)
    else $error("trap on a permitted op");
  trap_done_a: assert property (o_trap_q |-> o_done_q)
    else $error("trap without done");
  take_busy_a: assert property (take_s |=> o_busy_q || o_done_q)
    else $error("command not started");
  done_idle_a: assert property (o_done_q |-> !o_busy_q)
    else $error("busy during done");
  req_hold_a:
    assert property (o_mem_req_q && !i_mem_ack |=> o_mem_req_q &&
      $stable(o_mem_addr_q) && $stable(o_mem_wdata_q) && $stable(o_mem_we_q)
      && $stable(o_mem_size_q) && $stable(o_mem_fc_q))
    else $error("request moved before ack");
  req_drop_a: assert property (o_mem_req_q && i_mem_ack |=> !o_mem_req_q)
    else $error("request held after ack");
  rst_len_a:
    assert property ($fell(o_reset_line_q) |-> hi_q == P_RST_CYC)
    else $error("reset pulse length");
  rst_cap_a: assert property (hi_q <= P_RST_CYC)
    else $error("reset line pulse too long");
  rst_user_a:
    assert property (take_s ##0 (rst_op && !sup) |=>
      (!$rose(o_reset_line_q)) [*4])
    else $error("reset line in user state");
  rst_sup_a:
    assert property (take_s ##0 (rst_op && sup) |-> ##[1:4] o_reset_line_q)
    else $error("reset line not driven");
endmodule
bind ise_exec ise_exec_chk #(.P_LATER(P_LATER), .P_RST_CYC(P_RST_CYC))
  ise_exec_chk_inst (.*);
`default_nettype wire

// [ise_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ise_mem_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // request from the core
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  // answer delay in cycles
  input wire logic [1:0] i_lat,
  // answer to the core
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_q;
  // one ack per request; data toggles when not answering
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      wait_q <= 2'h0;
      o_rdata <= 32'h0;
    end else if (i_req && !o_ack && wait_q >= i_lat) begin
      o_ack <= 1'b1;
      wait_q <= 2'h0;
      if (i_we) mem[i_addr] = i_wdata;
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
    end else begin
      o_ack <= 1'b0;
      wait_q <= (i_req && !o_ack) ? wait_q + 2'h1 : 2'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_mclk = 0, i_nrst = 0, i_cmd_valid = 0, i_dir = 0, i_dst_mem = 0;
  logic [4:0] i_op = 0;
  logic [3:0] i_rx = 0, i_ry = 0, i_dbg_sel = 0;
  logic [1:0] i_size = 0, i_src_sel = 0, i_ctl_sel = 0, lat = 0, cs = 0;
  logic [1:0] sz = ise_pkg::SZ_L, o_mem_size_q;
  logic [31:0] i_imm = 0, i_ea = 0, i_mem_rdata, o_mem_addr_q, o_mem_wdata_q;
  logic [31:0] o_pc_q, o_dbg_data_q;
  logic [15:0] i_list = 0, ls = 0, o_sr_q;
  logic [2:0] o_mem_fc_q, fc_seen;
  logic i_mem_ack, o_busy_q, o_done_q, o_trap_q, o_mem_req_q, o_mem_we_q;
  logic o_reset_line_q, tp, dr = 0, dm = 0;
  int err_count = 0, n_compared = 0, rl_n = 0;
  ise_exec #(.P_RST_CYC(2)) ise_exec_inst (.*);
  ise_mem_model ise_mem_model_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_req(o_mem_req_q), .i_we(o_mem_we_q), .i_addr(o_mem_addr_q),
    .i_wdata(o_mem_wdata_q), .i_lat(lat), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));
  // clock and bus monitors
  initial forever #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_reset_line_q === 1'b1) rl_n++;
  always @(posedge i_mclk) if (o_mem_req_q && i_mem_ack) fc_seen <= o_mem_fc_q;
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [4:0] op, input logic [3:0] rx,
    input logic [3:0] ry = 4'h0, input logic [1:0] src = ise_pkg::SRC_REG,
    input logic [31:0] imm = 32'h0, input logic [31:0] ea = 32'h0);
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_op <= op;
    i_rx <= rx;
    i_ry <= ry;
    i_src_sel <= src;
    i_imm <= imm;
    i_ea <= ea;
    i_size <= sz;
    i_dir <= dr;
    i_dst_mem <= dm;
    i_list <= ls;
    i_ctl_sel <= cs;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(negedge i_mclk);
      if (o_done_q === 1'b1) break;
      if (k == 299) begin
        err_count++;
        close_out();
      end
    end
    tp = o_trap_q;
  endtask
  function automatic logic [31:0] m(input logic [31:0] a);
    return ise_mem_model_inst.mem[a];
  endfunction
  task automatic set_reg(input logic [3:0] r, input logic [31:0] val);
    ise_mem_model_inst.mem[32'h8000] = val;
    ls = 16'h0001 << r;
    dr = 1'b0;
    run(ise_pkg::OP_MVM, 4'h0, 4'h0, ise_pkg::SRC_MEM, 32'h0, 32'h8000);
  endtask
  task automatic pchk(input string nm, input logic [3:0] r,
                      input logic [31:0] e);
    @(posedge i_mclk);
    i_dbg_sel <= r;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk(nm, o_dbg_data_q, e);
  endtask
  task automatic t_stack();
    set_reg(4'hF, 32'h0000_1000);
    set_reg(4'hA, 32'hCAFE_0000);
    ls = 16'h0400;
    dr = 1'b1;
    run(ise_pkg::OP_MVM, 4'h0, 4'h0, ise_pkg::SRC_REG, 32'h0, 32'h3000);
    chk("mm store", m(32'h3000), 32'hCAFE_0000);
    run(ise_pkg::OP_LEA, 4'h9, 4'h0, ise_pkg::SRC_REG, 32'h0, 32'h1234);
    pchk("lea", 4'h9, 32'h0000_1234);
    run(ise_pkg::OP_LINK, 4'hA, 4'h0, ise_pkg::SRC_IMM, 32'hFFFF_FFF8);
    chk("link push", m(32'h0FFC), 32'hCAFE_0000);
    pchk("link frame", 4'hA, 32'h0000_0FFC);
    pchk("link sp", 4'hF, 32'h0000_0FF4);
    run(ise_pkg::OP_PEA, 4'h0, 4'h0, ise_pkg::SRC_REG, 32'h0, 32'hABCD);
    chk("pea", m(32'h0FF0), 32'h0000_ABCD);
    run(ise_pkg::OP_RTD, 4'h0, 4'h0, ise_pkg::SRC_IMM, 32'h4);
    chk("rtd pc", o_pc_q, 32'h0000_ABCD);
    pchk("rtd sp", 4'hF, 32'h0000_0FF8);
    $display("stack done");
  endtask
  task automatic t_arith();
    set_reg(4'h1, 32'h0000_FFFE);
    set_reg(4'h3, 32'h0000_FFFE);
    set_reg(4'h2, 32'h1234_0003);
    set_reg(4'h4, 32'h0000_0005);
    set_reg(4'h5, 32'h0000_0025);
    sz = ise_pkg::SZ_W;
    run(ise_pkg::OP_SIGNED_MULTIPLY, 4'h1, 4'h2);
    pchk("signed_multiply", 4'h1, 32'hFFFF_FFFA);
    run(ise_pkg::OP_UNSIGNED_MULTIPLY, 4'h3, 4'h2);
    pchk("unsigned_multiply", 4'h3, 32'h0002_FFFA);
    sz = ise_pkg::SZ_L;
    run(ise_pkg::OP_NEG, 4'h4);
    pchk("neg", 4'h4, 32'hFFFF_FFFB);
    run(ise_pkg::OP_COMPLEMENT_WITH_EXTEND, 4'h4);
    pchk("complement_with_extend", 4'h4, 32'h0000_0004);
    sz = ise_pkg::SZ_B;
    run(ise_pkg::OP_DECIMAL_NEGATE, 4'h5);
    pchk("decimal_negate", 4'h5, 32'h0000_0074);
    chk("decimal_negate borrow", o_sr_q[4], 1'b1);
    sz = ise_pkg::SZ_L;
    $display("arith done");
  endtask
  task automatic t_shift();
    logic [4:0] ops [6] = '{ise_pkg::OP_LSH, ise_pkg::OP_LSH, ise_pkg::OP_ROT,
      ise_pkg::OP_ROT, ise_pkg::OP_ROX, ise_pkg::OP_ROX};
    logic [31:0] e [6] = '{32'h4, 32'h4000_0001, 32'h5, 32'h4000_0001, 32'h4,
      32'hC000_0001};
    logic [5:0] xe = 6'b010001;
    for (int i = 0; i < 6; i++) begin
      set_reg(4'h6, 32'h8000_0002);
      dr = ~i[0];
      run(ops[i], 4'h6, 4'h0, ise_pkg::SRC_IMM, 32'h1);
      pchk("shift", 4'h6, e[i]);
      chk("extend", o_sr_q[4], xe[i]);
    end
    $display("shift done");
  endtask
  task automatic t_or();
    lat = 2'h2;
    set_reg(4'h7, 32'h0000_00F0);
    run(ise_pkg::OP_ORI, 4'h7, 4'h0, ise_pkg::SRC_IMM, 32'h0F);
    pchk("ori", 4'h7, 32'h0000_00FF);
    ise_mem_model_inst.mem[32'h2000] = 32'h0000_0F00;
    dm = 1'b1;
    run(ise_pkg::OP_OR, 4'h0, 4'h7, ise_pkg::SRC_REG, 32'h0, 32'h2000);
    dm = 1'b0;
    chk("or to mem", m(32'h2000), 32'h0000_0FFF);
    run(ise_pkg::OP_OR, 4'h7, 4'h0, ise_pkg::SRC_MEM, 32'h0, 32'h2000);
    pchk("or to reg", 4'h7, 32'h0000_0FFF);
    lat = 2'h0;
    $display("or done");
  endtask
  task automatic t_priv();
    logic [4:0] pv [7] = '{ise_pkg::OP_MVTSR, ise_pkg::OP_MVUSP,
      ise_pkg::OP_MVC, ise_pkg::OP_MVS, ise_pkg::OP_ORISR, ise_pkg::OP_RST,
      ise_pkg::OP_MVFSR};
    set_reg(4'h8, 32'h0000_3000);
    set_reg(4'h0, 32'h0000_0003);
    dr = 1'b1;
    cs = ise_pkg::CTL_DFC;
    run(ise_pkg::OP_MVUSP, 4'h8);
    run(ise_pkg::OP_MVC, 4'h0);
    run(ise_pkg::OP_MVS, 4'h0, 4'h0, ise_pkg::SRC_REG, 32'h0, 32'h2100);
    chk("alt space fc", fc_seen, 32'h3);
    chk("alt space data", m(32'h2100), 32'h3);
    dr = 1'b0;
    run(ise_pkg::OP_MVUSP, 4'hB);
    pchk("usp", 4'hB, 32'h0000_3000);
    run(ise_pkg::OP_MVC, 4'h1);
    pchk("control", 4'h1, 32'h0000_0003);
    rl_n = 0;
    run(ise_pkg::OP_RST, 4'h0);
    repeat (6) @(posedge i_mclk);
    chk("reset line", rl_n, 32'h2);
    sz = ise_pkg::SZ_W;
    run(ise_pkg::OP_ORISR, 4'h0, 4'h0, ise_pkg::SRC_IMM, 32'h0010);
    chk("or status", o_sr_q, 32'h2710);
    run(ise_pkg::OP_MVFSR, 4'h2);
    pchk("status read", 4'h2, 32'h1234_2710);
    run(ise_pkg::OP_MVTSR, 4'h0, 4'h0, ise_pkg::SRC_IMM, 32'h0700);
    chk("to user", o_sr_q, 32'h0700);
    rl_n = 0;
    for (int i = 0; i < 7; i++) begin
      run(pv[i], 4'h1, 4'h0, ise_pkg::SRC_IMM, 32'h2000, 32'h2100);
      chk("trap", tp, 1'b1);
      chk("status kept", o_sr_q, 32'h0700);
    end
    chk("no reset line", rl_n, 32'h0);
    run(ise_pkg::OP_LEA, 4'h9, 4'h0, ise_pkg::SRC_REG, 32'h0, 32'h55);
    chk("user lea", tp, 1'b0);
    $display("priv done");
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_stack();
    t_arith();
    t_shift();
    t_or();
    t_priv();
    close_out();
  end
endmodule
`default_nettype wire
